// File: core/fmap_defs.svh
// Purpose: address constants for the flash bank address map
// Assumes: 32-bit byte addresses, all bases aligned to their sector size
// Notes:   counts are sector counts per decode window, shifts are log2 of sector size
`ifndef FMAP_DEFS_SVH
`define FMAP_DEFS_SVH

// ----------------------------------------------------------------------------
// code-flash bases
// ----------------------------------------------------------------------------
`define FMAP_CODE_LO_BASE    32'h1000_0000
`define FMAP_CODE_HI_BASE    32'h1200_0000
`define FMAP_CODE_SB_SS_BASE 32'h107F_0000
`define FMAP_CODE_LO_SS_BASE 32'h103F_8000
`define FMAP_CODE_HI_SS_BASE 32'h123F_8000
`define FMAP_CODE_SB_END     32'h1083_0000
`define FMAP_CODE_DB_END     32'h1041_8000

// ----------------------------------------------------------------------------
// work-flash bases
// ----------------------------------------------------------------------------
`define FMAP_WORK_LO_BASE    32'h1400_0000
`define FMAP_WORK_HI_BASE    32'h1500_0000
`define FMAP_WORK_SB_SS_BASE 32'h1403_0000
`define FMAP_WORK_LO_SS_BASE 32'h1401_8000
`define FMAP_WORK_HI_SS_BASE 32'h1501_8000
`define FMAP_WORK_SB_END     32'h1404_0000
`define FMAP_WORK_DB_END     32'h1402_0000
`define FMAP_WORK_HI_END     32'h1502_0000

// ----------------------------------------------------------------------------
// sector counts and sizes
// ----------------------------------------------------------------------------
`define FMAP_CODE_SB_LS_CNT  10'h0FE
`define FMAP_CODE_SB_SS_CNT  10'h020
`define FMAP_CODE_DB_LS_CNT  10'h07F
`define FMAP_CODE_DB_SS_CNT  10'h010
`define FMAP_WORK_SB_LS_CNT  10'h060
`define FMAP_WORK_SB_SS_CNT  10'h200
`define FMAP_WORK_DB_LS_CNT  10'h030
`define FMAP_WORK_DB_SS_CNT  10'h100
`define FMAP_CODE_LS_SHIFT   15
`define FMAP_CODE_SS_SHIFT   13
`define FMAP_WORK_LS_SHIFT   11
`define FMAP_WORK_SS_SHIFT   7

`endif

// File: core/fmap_half_dec.sv
// Purpose: decode one flash half into large and small sector windows
// Assumes: bases aligned to sector size, windows of one half do not overlap
// Notes:   bases and counts are live inputs so the mode can change at run time
`timescale 1ns/100ps
`default_nettype none
module fmap_half_dec #(
    parameter int LS_SHIFT = 15,
    parameter int SS_SHIFT = 13
) (
    input  wire logic [31:0] addr,
    input  wire logic        enable,
    input  wire logic [31:0] ls_base,
    input  wire logic [31:0] ss_base,
    input  wire logic [9:0]  ls_count,
    input  wire logic [9:0]  ss_count,
    fmap_hit_if.dec          res
);
    // ------------------------------------------------------------------------
    // window arithmetic
    // ------------------------------------------------------------------------
    // relative address wraps below the base, hence the extra compare
    wire [31:0] ls_rel  = addr - ls_base;
    wire [31:0] ss_rel  = addr - ss_base;
    wire [31:0] ls_lim  = {22'h0, ls_count} << LS_SHIFT;
    wire [31:0] ss_lim  = {22'h0, ss_count} << SS_SHIFT;
    wire [31:0] ls_mask = (32'h1 << LS_SHIFT) - 32'h1;
    wire [31:0] ss_mask = (32'h1 << SS_SHIFT) - 32'h1;
    wire [31:0] ls_idx  = ls_rel >> LS_SHIFT;
    wire [31:0] ss_idx  = ss_rel >> SS_SHIFT;
    wire [31:0] ls_ofs  = ls_rel & ls_mask;
    wire [31:0] ss_ofs  = ss_rel & ss_mask;
    wire        ls_hit  = enable && (addr >= ls_base) && (ls_rel < ls_lim);
    wire        ss_hit  = enable && (addr >= ss_base) && (ss_rel < ss_lim);

    // ------------------------------------------------------------------------
    // result
    // ------------------------------------------------------------------------
    // fields read zero on a miss so a stray result never looks valid
    assign res.hit    = ls_hit | ss_hit;
    assign res.is_small = ss_hit;
    assign res.sector = ls_hit ? ls_idx[8:0]  : (ss_hit ? ss_idx[8:0]  : 9'h000);
    assign res.offset = ls_hit ? ls_ofs[14:0] : (ss_hit ? ss_ofs[14:0] : 15'h0000);
endmodule : fmap_half_dec
`default_nettype wire

// File: core/fmap_hit_if.sv
// Purpose: carries one decode window result between modules
// Assumes: combinational producer
// Notes:   dec drives, sink reads
`timescale 1ns/100ps
`default_nettype none
interface fmap_hit_if;
    logic                  hit;
    logic                  is_small;
    fmap_pkg::fmap_sector_t sector;
    fmap_pkg::fmap_offset_t offset;
    modport dec  (output hit, output is_small, output sector, output offset);
    modport sink (input hit, input is_small, input sector, input offset);
endinterface : fmap_hit_if
`default_nettype wire

// File: core/fmap_out_stage.sv
// Purpose: register the selected decode result toward the requester
// Assumes: one request per cycle, no back-pressure
// Notes:   unmapped answers carry zero in every field
`timescale 1ns/100ps
`default_nettype none
module fmap_out_stage (
    input  wire logic                    core_clk,
    input  wire logic                    resetn,
    input  wire logic                    in_valid,
    input  wire logic                    in_work,
    input  wire logic                    in_bank,
    fmap_hit_if.sink                     sel,
    output logic                         rsp_valid,
    output fmap_pkg::fmap_region_t       rsp_region,
    output logic                         rsp_bank,
    output logic                         rsp_small,
    output fmap_pkg::fmap_sector_t       rsp_sector,
    output fmap_pkg::fmap_offset_t       rsp_offset,
    output logic                         rsp_unmapped
);
    // ------------------------------------------------------------------------
    // answer register
    // ------------------------------------------------------------------------
    wire take = in_valid & sel.hit;

    // fields hold between requests to keep the bus quiet
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rsp_valid    <= 1'b0;
            rsp_region   <= fmap_pkg::FMAP_REGION_CODE;
            rsp_bank     <= 1'b0;
            rsp_small    <= 1'b0;
            rsp_sector   <= 9'h000;
            rsp_offset   <= 15'h0000;
            rsp_unmapped <= 1'b0;
        end else begin
            rsp_valid <= in_valid;
            if (in_valid) begin
                rsp_region   <= (take & in_work) ? fmap_pkg::FMAP_REGION_WORK
                                                 : fmap_pkg::FMAP_REGION_CODE;
                rsp_bank     <= take & in_bank;
                rsp_small    <= take & sel.is_small;
                rsp_sector   <= take ? sel.sector : 9'h000;
                rsp_offset   <= take ? sel.offset : 15'h0000;
                rsp_unmapped <= ~sel.hit;
            end
        end
    end
endmodule : fmap_out_stage
`default_nettype wire

// File: core/fmap_pkg.sv
// Purpose: shared types of the flash bank address map
// Assumes: nothing beyond the defs header
// Notes:   sector index covers up to 512 sectors, offset up to 32 KB
package fmap_pkg;
    typedef enum logic {
        FMAP_REGION_CODE = 1'b0,
        FMAP_REGION_WORK = 1'b1
    } fmap_region_t;
    typedef logic [8:0]  fmap_sector_t;
    typedef logic [14:0] fmap_offset_t;
endpackage : fmap_pkg

// File: core/fmap_top.sv
// Purpose: map flash addresses onto code and work sector arrays
// Assumes: mode inputs come from flash controller logic on core_clk
// Notes:   one answer per request, one cycle later
//
// Contract
// - code-flash is single or dual bank by its own control bit.
// - work-flash is single or dual bank by its own bit; 256 KB total.
// - single code: 254 x 32 KB at 0x10000000, 32 x 8 KB at 0x107F0000.
// - dual code: two banks, each 127 large and 16 small sectors.
// - mapping A: first code half low at 0x10000000, second at 0x12000000.
// - mapping B swaps code halves between the two bases.
// - single work: 96 x 2 KB at 0x14000000, 512 x 128 B at 0x14030000.
// - mapping A work: halves at 0x14000000 and 0x15000000, 48 and 256 sectors.
// - mapping B swaps work halves between the two bases.
// - dual work banks hold 128 KB each; single bank is 256 KB contiguous.
`timescale 1ns/100ps
`default_nettype none
`include "fmap_defs.svh"
module fmap_top (
    input  wire logic                    core_clk,
    input  wire logic                    resetn,
    input  wire logic                    req_valid,
    input  wire logic [31:0]             req_addr,
    input  wire logic                    code_dual_bank,
    input  wire logic                    work_dual_bank,
    input  wire logic                    dual_map_b,
    output logic                         rsp_valid,
    output fmap_pkg::fmap_region_t       rsp_region,
    output logic                         rsp_bank,
    output logic                         rsp_small,
    output fmap_pkg::fmap_sector_t       rsp_sector,
    output fmap_pkg::fmap_offset_t       rsp_offset,
    output logic                         rsp_unmapped
);
    // ------------------------------------------------------------------------
    // mode decode
    // ------------------------------------------------------------------------
    // mapping select only matters in dual mode; single mode ignores it
    wire code_swap = code_dual_bank & dual_map_b;
    wire work_swap = work_dual_bank & dual_map_b;

    // slot 0/1 = code first/second half, slot 2/3 = work first/second half
    wire [31:0] slot_ls_base [4];
    wire [31:0] slot_ss_base [4];
    wire [9:0]  slot_ls_cnt  [4];
    wire [9:0]  slot_ss_cnt  [4];
    wire [3:0]  slot_en;

    // code first half: one contiguous bank in single mode
    assign slot_en[0]      = 1'b1;
    assign slot_ls_base[0] = code_swap ? `FMAP_CODE_HI_BASE : `FMAP_CODE_LO_BASE;
    assign slot_ss_base[0] = !code_dual_bank ? `FMAP_CODE_SB_SS_BASE
                           : (code_swap ? `FMAP_CODE_HI_SS_BASE : `FMAP_CODE_LO_SS_BASE);
    assign slot_ls_cnt[0]  = code_dual_bank ? `FMAP_CODE_DB_LS_CNT : `FMAP_CODE_SB_LS_CNT;
    assign slot_ss_cnt[0]  = code_dual_bank ? `FMAP_CODE_DB_SS_CNT : `FMAP_CODE_SB_SS_CNT;

    // code second half exists only in dual mode
    assign slot_en[1]      = code_dual_bank;
    assign slot_ls_base[1] = code_swap ? `FMAP_CODE_LO_BASE : `FMAP_CODE_HI_BASE;
    assign slot_ss_base[1] = code_swap ? `FMAP_CODE_LO_SS_BASE : `FMAP_CODE_HI_SS_BASE;
    assign slot_ls_cnt[1]  = `FMAP_CODE_DB_LS_CNT;
    assign slot_ss_cnt[1]  = `FMAP_CODE_DB_SS_CNT;

    // work first half: whole 256 KB in single mode
    assign slot_en[2]      = 1'b1;
    assign slot_ls_base[2] = work_swap ? `FMAP_WORK_HI_BASE : `FMAP_WORK_LO_BASE;
    assign slot_ss_base[2] = !work_dual_bank ? `FMAP_WORK_SB_SS_BASE
                           : (work_swap ? `FMAP_WORK_HI_SS_BASE : `FMAP_WORK_LO_SS_BASE);
    assign slot_ls_cnt[2]  = work_dual_bank ? `FMAP_WORK_DB_LS_CNT : `FMAP_WORK_SB_LS_CNT;
    assign slot_ss_cnt[2]  = work_dual_bank ? `FMAP_WORK_DB_SS_CNT : `FMAP_WORK_SB_SS_CNT;

    // work second half: 128 KB bank only in dual mode
    assign slot_en[3]      = work_dual_bank;
    assign slot_ls_base[3] = work_swap ? `FMAP_WORK_LO_BASE : `FMAP_WORK_HI_BASE;
    assign slot_ss_base[3] = work_swap ? `FMAP_WORK_LO_SS_BASE : `FMAP_WORK_HI_SS_BASE;
    assign slot_ls_cnt[3]  = `FMAP_WORK_DB_LS_CNT;
    assign slot_ss_cnt[3]  = `FMAP_WORK_DB_SS_CNT;

    // ------------------------------------------------------------------------
    // decode windows
    // ------------------------------------------------------------------------
    wire [3:0]              slot_hit;
    wire [3:0]              slot_small;
    fmap_pkg::fmap_sector_t slot_sector [4];
    fmap_pkg::fmap_offset_t slot_offset [4];

    for (genvar s = 0; s < 4; s++) begin : g_slot
        fmap_hit_if res_if ();
        fmap_half_dec #(
            .LS_SHIFT (s < 2 ? `FMAP_CODE_LS_SHIFT : `FMAP_WORK_LS_SHIFT),
            .SS_SHIFT (s < 2 ? `FMAP_CODE_SS_SHIFT : `FMAP_WORK_SS_SHIFT)
        ) u_dec (
            .addr     (req_addr),
            .enable   (slot_en[s]),
            .ls_base  (slot_ls_base[s]),
            .ss_base  (slot_ss_base[s]),
            .ls_count (slot_ls_cnt[s]),
            .ss_count (slot_ss_cnt[s]),
            .res      (res_if.dec)
        );
        assign slot_hit[s]    = res_if.hit;
        assign slot_small[s]  = res_if.is_small;
        assign slot_sector[s] = res_if.sector;
        assign slot_offset[s] = res_if.offset;
    end

    // ------------------------------------------------------------------------
    // selection
    // ------------------------------------------------------------------------
    // windows never overlap, so the priority order only settles x-free muxing
    wire [1:0] slot_idx = slot_hit[0] ? 2'h0 : (slot_hit[1] ? 2'h1 :
                          (slot_hit[2] ? 2'h2 : 2'h3));
    wire       sel_work = slot_idx[1];
    // bank index is the physical half, whichever base it answers at
    wire       sel_bank = slot_idx[0];

    fmap_hit_if sel_if ();
    assign sel_if.hit    = |slot_hit;
    assign sel_if.is_small = slot_small[slot_idx];
    assign sel_if.sector = slot_sector[slot_idx];
    assign sel_if.offset = slot_offset[slot_idx];

    fmap_out_stage u_out (
        .core_clk     (core_clk),
        .resetn       (resetn),
        .in_valid     (req_valid),
        .in_work      (sel_work),
        .in_bank      (sel_bank),
        .sel          (sel_if.sink),
        .rsp_valid    (rsp_valid),
        .rsp_region   (rsp_region),
        .rsp_bank     (rsp_bank),
        .rsp_small    (rsp_small),
        .rsp_sector   (rsp_sector),
        .rsp_offset   (rsp_offset),
        .rsp_unmapped (rsp_unmapped)
    );

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    // every request answered exactly one cycle later
    chk_rsp_timing: assert property (
        @(posedge core_clk) disable iff (!resetn)
        req_valid |=> rsp_valid ##1 (rsp_valid == $past(req_valid)))
        else $error("answer not one cycle after request");

    // single-bank code large sectors, sector and offset from address
    chk_code_single_ls: assert property (
        @(posedge core_clk) disable iff (!resetn)
        req_valid && !code_dual_bank && req_addr >= `FMAP_CODE_LO_BASE
            && req_addr < `FMAP_CODE_SB_SS_BASE
        |=> !rsp_unmapped && rsp_region == fmap_pkg::FMAP_REGION_CODE && !rsp_bank
            && !rsp_small && rsp_sector == 9'($past(req_addr) >> 15)
            && rsp_offset == $past(req_addr[14:0]))
        else $error("single code large sector misdecoded");

    // single-bank code small sectors follow the large ones
    chk_code_single_ss: assert property (
        @(posedge core_clk) disable iff (!resetn)
        req_valid && !code_dual_bank && req_addr >= `FMAP_CODE_SB_SS_BASE
            && req_addr < `FMAP_CODE_SB_END
        |=> !rsp_unmapped && rsp_small && !rsp_bank
            && rsp_sector == 9'(($past(req_addr) - `FMAP_CODE_SB_SS_BASE) >> 13))
        else $error("single code small sector misdecoded");

    // mapping A upper base belongs to the second half
    chk_code_map_a: assert property (
        @(posedge core_clk) disable iff (!resetn)
        req_valid && code_dual_bank && !dual_map_b && req_addr >= `FMAP_CODE_HI_SS_BASE
            && req_addr < `FMAP_CODE_HI_SS_BASE + 32'h0002_0000
        |=> !rsp_unmapped && rsp_bank && rsp_small
            && rsp_sector == 9'(($past(req_addr) - `FMAP_CODE_HI_SS_BASE) >> 13))
        else $error("mapping A code second half misdecoded");

    // mapping B lower base belongs to the second half
    chk_code_map_b: assert property (
        @(posedge core_clk) disable iff (!resetn)
        req_valid && code_dual_bank && dual_map_b && req_addr >= `FMAP_CODE_LO_BASE
            && req_addr < `FMAP_CODE_LO_SS_BASE
        |=> !rsp_unmapped && rsp_bank && !rsp_small
            && rsp_sector == 9'($past(req_addr) >> 15))
        else $error("mapping B code half swap wrong");

    // dual code bank ends after 127 large plus 16 small sectors
    chk_code_dual_end: assert property (
        @(posedge core_clk) disable iff (!resetn)
        req_valid && code_dual_bank && req_addr >= `FMAP_CODE_DB_END
            && req_addr < `FMAP_CODE_SB_END
        |=> rsp_unmapped && rsp_sector == 9'h000)
        else $error("address beyond dual code bank was mapped");

    // single-bank work small sectors of 128 B
    chk_work_single_ss: assert property (
        @(posedge core_clk) disable iff (!resetn)
        req_valid && !work_dual_bank && req_addr >= `FMAP_WORK_SB_SS_BASE
            && req_addr < `FMAP_WORK_SB_END
        |=> !rsp_unmapped && rsp_region == fmap_pkg::FMAP_REGION_WORK && rsp_small
            && !rsp_bank && rsp_sector == 9'(($past(req_addr) - `FMAP_WORK_SB_SS_BASE) >> 7)
            && rsp_offset == 15'($past(req_addr[6:0])))
        else $error("single work small sector misdecoded");

    // upper work small window: second half in A, first half in B
    chk_work_swap: assert property (
        @(posedge core_clk) disable iff (!resetn)
        req_valid && work_dual_bank && req_addr >= `FMAP_WORK_HI_SS_BASE
            && req_addr < `FMAP_WORK_HI_END
        |=> !rsp_unmapped && rsp_small && (rsp_bank == !$past(dual_map_b)))
        else $error("work half swap wrong");

    // dual work bank stops at 128 KB
    chk_work_dual_cap: assert property (
        @(posedge core_clk) disable iff (!resetn)
        req_valid && work_dual_bank && req_addr >= `FMAP_WORK_DB_END
            && req_addr < `FMAP_WORK_SB_END
        |=> rsp_unmapped)
        else $error("work address beyond 128 KB bank was mapped");

    // mapping A work large sectors in the second half
    chk_work_map_a: assert property (
        @(posedge core_clk) disable iff (!resetn)
        req_valid && work_dual_bank && !dual_map_b && req_addr >= `FMAP_WORK_HI_BASE
            && req_addr < `FMAP_WORK_HI_SS_BASE
        |=> !rsp_unmapped && rsp_bank && !rsp_small
            && rsp_sector == 9'(($past(req_addr) - `FMAP_WORK_HI_BASE) >> 11))
        else $error("mapping A work large sector misdecoded");

    // below code-flash nothing answers
    chk_low_unmapped: assert property (
        @(posedge core_clk) disable iff (!resetn)
        req_valid && req_addr < `FMAP_CODE_LO_BASE
        |=> rsp_unmapped && !rsp_small && rsp_offset == 15'h0000)
        else $error("address below flash was mapped");
endmodule : fmap_top
`default_nettype wire

// File: testbench/fmap_req_model.sv
// Purpose: bus master model issuing flash addresses to the map
// Assumes: caller stands at a falling edge of core_clk
// Notes:   no back-pressure, so a request is taken at the next rising edge
`timescale 1ns/100ps
`default_nettype none
module fmap_req_model (
    input  wire logic        core_clk,
    output var  logic        req_valid,
    output var  logic [31:0] req_addr
);
    // idle bus before the first request
    initial begin
        req_valid = 1'b0;
        req_addr  = 32'h0000_0000;
    end

    // one request; keep leaves the strobe up for a back to back follower
    task automatic send(input logic [31:0] addr, input logic keep);
        req_valid = 1'b1;
        req_addr  = addr;
        @(negedge core_clk);
        if (!keep) begin
            req_valid = 1'b0;
            req_addr  = ~addr; // released bus must not show a stale address
        end
    endtask : send
endmodule : fmap_req_model
`default_nettype wire

// File: testbench/testbench.sv
// Purpose: self-checking bench for the flash bank address map
// Assumes: answers registered at the taking edge, sampled at the next falling edge
// Notes:   expected fields are worked out by hand from the sector tables
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic                   core_clk;
    logic                   resetn;
    logic                   code_dual_bank;
    logic                   work_dual_bank;
    logic                   dual_map_b;
    logic                   req_valid;
    logic [31:0]            req_addr;
    logic                   rsp_valid;
    logic                   rsp_bank;
    logic                   rsp_small;
    logic                   rsp_unmapped;
    fmap_pkg::fmap_region_t rsp_region;
    fmap_pkg::fmap_sector_t rsp_sector;
    fmap_pkg::fmap_offset_t rsp_offset;
    int                     fails;
    int                     checks_done;
    int                     cycles;
    localparam logic [28:0] UNM = 29'h1800_0000; // valid and unmapped, rest zero
    wire logic [28:0] rsp_all = {rsp_valid, rsp_unmapped, rsp_region, rsp_bank,
                                 rsp_small, rsp_sector, rsp_offset};

    fmap_top i_fmap_top (.core_clk(core_clk), .resetn(resetn), .req_valid(req_valid),
        .req_addr(req_addr), .code_dual_bank(code_dual_bank),
        .work_dual_bank(work_dual_bank), .dual_map_b(dual_map_b),
        .rsp_valid(rsp_valid), .rsp_region(rsp_region), .rsp_bank(rsp_bank),
        .rsp_small(rsp_small), .rsp_sector(rsp_sector), .rsp_offset(rsp_offset),
        .rsp_unmapped(rsp_unmapped));
    fmap_req_model i_fmap_req_model (.core_clk(core_clk), .req_valid(req_valid),
        .req_addr(req_addr));

    // ------------------------------------------------------------------
    // clock, timeout and helpers
    // ------------------------------------------------------------------
    initial core_clk = 1'b0;
    always #12.5 core_clk = ~core_clk;
    // the whole run needs about 40 cycles; 500 means a hang
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 500) begin
            fails = fails + 1;
            close_out();
        end
    end
    task automatic chk(input logic [28:0] seen, input logic [28:0] exp);
        checks_done = checks_done + 1;
        if (seen !== exp) begin
            fails = fails + 1;
            $display("[ERR] %0t answer %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // one request, strobe left up for the next one so it never glitches low
    task automatic probe(input logic [31:0] a, input logic r, input logic b,
                         input logic s, input logic [8:0] sec, input logic [14:0] off);
        i_fmap_req_model.send(a, 1'b1);
        chk(rsp_all, {2'b10, r, b, s, sec, off});
    endtask : probe
    task automatic probe_unm(input logic [31:0] a);
        i_fmap_req_model.send(a, 1'b1);
        chk(rsp_all, UNM);
    endtask : probe_unm
    task automatic set_mode(input logic c, input logic w, input logic b);
        code_dual_bank = c;
        work_dual_bank = w;
        dual_map_b     = b;
    endtask : set_mode

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_code_single();
        set_mode(1'b0, 1'b0, 1'b1); // map bit must be ignored in single mode
        probe(32'h1000_0000, 1'b0, 1'b0, 1'b0, 9'h000, 15'h0000);
        probe(32'h107E_FFFF, 1'b0, 1'b0, 1'b0, 9'h0FD, 15'h7FFF);
        probe(32'h107F_2000, 1'b0, 1'b0, 1'b1, 9'h001, 15'h0000);
        probe(32'h1082_FFFF, 1'b0, 1'b0, 1'b1, 9'h01F, 15'h1FFF);
        probe_unm(32'h1083_0000);
        probe_unm(32'h1200_0000);
        $display("code single done");
    endtask : t_code_single
    task automatic t_code_dual();
        set_mode(1'b1, 1'b0, 1'b0);
        probe(32'h103F_7FFF, 1'b0, 1'b0, 1'b0, 9'h07E, 15'h7FFF);
        probe(32'h103F_8000, 1'b0, 1'b0, 1'b1, 9'h000, 15'h0000);
        probe(32'h1041_7FFF, 1'b0, 1'b0, 1'b1, 9'h00F, 15'h1FFF);
        probe_unm(32'h1041_8000);
        probe(32'h1200_8123, 1'b0, 1'b1, 1'b0, 9'h001, 15'h0123);
        probe(32'h123F_A000, 1'b0, 1'b1, 1'b1, 9'h001, 15'h0000);
        probe(32'h1403_0000, 1'b1, 1'b0, 1'b1, 9'h000, 15'h0000);
        set_mode(1'b1, 1'b0, 1'b1);
        probe(32'h1200_8123, 1'b0, 1'b0, 1'b0, 9'h001, 15'h0123);
        probe(32'h1000_0000, 1'b0, 1'b1, 1'b0, 9'h000, 15'h0000);
        probe(32'h103F_8000, 1'b0, 1'b1, 1'b1, 9'h000, 15'h0000);
        probe(32'h1403_0080, 1'b1, 1'b0, 1'b1, 9'h001, 15'h0000);
        $display("code dual done");
    endtask : t_code_dual
    task automatic t_work();
        set_mode(1'b0, 1'b0, 1'b0);
        probe(32'h1402_FFFF, 1'b1, 1'b0, 1'b0, 9'h05F, 15'h07FF);
        probe(32'h1403_FFFF, 1'b1, 1'b0, 1'b1, 9'h1FF, 15'h007F);
        probe_unm(32'h1404_0000);
        probe_unm(32'h1500_0000);
        set_mode(1'b0, 1'b1, 1'b0);
        probe(32'h1401_7FFF, 1'b1, 1'b0, 1'b0, 9'h02F, 15'h07FF);
        probe(32'h1401_FFFF, 1'b1, 1'b0, 1'b1, 9'h0FF, 15'h007F);
        probe_unm(32'h1402_0000);
        probe(32'h1500_0800, 1'b1, 1'b1, 1'b0, 9'h001, 15'h0000);
        probe(32'h1501_8000, 1'b1, 1'b1, 1'b1, 9'h000, 15'h0000);
        probe(32'h107F_0000, 1'b0, 1'b0, 1'b1, 9'h000, 15'h0000);
        set_mode(1'b0, 1'b1, 1'b1);
        probe(32'h1500_0800, 1'b1, 1'b0, 1'b0, 9'h001, 15'h0000);
        probe(32'h1401_8000, 1'b1, 1'b1, 1'b1, 9'h000, 15'h0000);
        probe(32'h1501_FFFF, 1'b1, 1'b0, 1'b1, 9'h0FF, 15'h007F);
        probe_unm(32'h1700_2000);
        $display("work done");
    endtask : t_work
    // back to back requests, then the fields must hold with the strobe low
    task automatic t_back_to_back();
        set_mode(1'b1, 1'b1, 1'b0);
        i_fmap_req_model.send(32'h1200_0000, 1'b1);
        chk(rsp_all, 29'h1200_0000);
        i_fmap_req_model.send(32'h0000_0000, 1'b1);
        chk(rsp_all, UNM);
        i_fmap_req_model.send(32'h1501_0080, 1'b0);
        @(negedge core_clk);
        chk(rsp_all, 29'h0610_0080);
        $display("back to back done");
    endtask : t_back_to_back

    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : close_out

    // reset for 3 cycles, outputs quiet, then the scenarios
    initial begin
        fails       = 0;
        checks_done = 0;
        cycles      = 0;
        resetn      = 1'b0;
        set_mode(1'b0, 1'b0, 1'b0);
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
        chk(rsp_all, 29'h0000_0000);
        resetn = 1'b1;
        @(negedge core_clk);
        chk(rsp_all, 29'h0000_0000);
        t_code_single();
        t_code_dual();
        t_work();
        t_back_to_back();
        close_out();
    end
endmodule : testbench
`default_nettype wire
